// ===== design/pixel_path_test_mode_control.sv
// pixel path test mode control with its axi4-lite register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pixel_test_defs.svh"

// What this block does
// - The normal setting passes the analog stage to the converter; a second bypasses the stage.
// - Two settings bypass stage and correction, giving the raw high or raw low converter part.
// - The converter code reads as two bytes, the high part first and the low part next.
// - A two-bit selector feeds the divider from converter, code registers, or either counter.
// - With the per-scan source, the 16-bit counter clears at every scan start.
// - With the per-line source, the 16-bit counter clears at every line start.
// - The counter starts at zero and advances once per data pixel sent to the divider.
// - A two-bit selector sets the step to 1, 4 or 16, the fourth code being unused.
// - One bit picks the rising or falling sampling clock edge; software keeps it at zero.
// - One bit puts the sampling strobe on the second lamp output, else the pin is normal.
// - The converter word is 16 bits with the 14-bit code on top and two zero low bits.
// - The divider lowers resolution by averaging adjacent pixels, not by dropping them.
module pixel_path_test_mode_control #(
  parameter int ADDR_W = 12,
  parameter int MAX_DIV = 12
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // converter and scan framing
  input wire logic i_conv_valid,
  input wire logic [`CONV_CODE_W-1:0] i_conv_code,
  input wire logic i_scan_start,
  input wire logic i_line_start,
  input wire logic [3:0] i_divide_by,
  // strobe and lamp
  input wire logic i_correlated_sampling_strobe,
  input wire logic i_lamp_normal,
  // analog and converter controls
  output logic o_analog_input_stage_bypass,
  output logic o_correction_bypass,
  output logic o_raw_low_select,
  output logic o_sample_falling_edge,
  output logic o_second_lamp_output,
  // averaged pixels
  output logic o_pix_valid,
  output logic [15:0] o_pix_data
);

  generate
    if (ADDR_W < 10) begin : g_bad_addr
      $error("address width too small for the register map");
    end
  endgenerate

  localparam logic [7:0] IDX_CTRL = `IDX_TEST_PATH_CONTROL;
  localparam logic [7:0] IDX_HIGH = `IDX_CONVERTER_CODE_HIGH;
  localparam logic [7:0] IDX_LOW = `IDX_CONVERTER_CODE_LOW;
  localparam logic [7:0] IDX_RSVD = `IDX_RESERVED_FIRST;

  // word index of a byte address; upper bits must be zero to hit the map
  function automatic logic [8:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] upper;
    upper = addr >> 10;
    word_index = {(upper != '0) || (addr[1:0] != 2'b00), addr[9:2]};
  endfunction : word_index

  // registers
  logic [7:0] test_path_control;
  logic [15:0] code_word;
  logic [15:0] count;
  logic div_valid;
  logic [15:0] div_data;

  pixel_test_pkg::test_mode_t test_mode;
  pixel_test_pkg::input_sel_t input_sel;
  pixel_test_pkg::step_sel_t step_sel;

  assign test_mode = pixel_test_pkg::test_mode_t'(
    test_path_control[`FLD_TEST_MODE_MSB:`FLD_TEST_MODE_LSB]);
  assign input_sel = pixel_test_pkg::input_sel_t'(
    test_path_control[`FLD_INPUT_SEL_MSB:`FLD_INPUT_SEL_LSB]);
  assign step_sel = pixel_test_pkg::step_sel_t'(
    test_path_control[`FLD_STEP_SEL_MSB:`FLD_STEP_SEL_LSB]);

  // ---------------- axi4-lite write side ----------------
  logic aw_held;
  logic w_held;
  logic [8:0] aw_index;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign do_write = aw_held && w_held && !o_bvalid;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      aw_index <= 9'h000;
      o_awready <= 1'b0;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_held <= 1'b1;
        aw_index <= word_index(i_awaddr);
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      o_awready <= !aw_held && !o_awready && !o_bvalid;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_wready <= 1'b0;
    end else begin
      if (o_wready && i_wvalid) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      o_wready <= !w_held && !o_wready && !o_bvalid;
    end
  end

  // the first reserved word accepts the write and keeps nothing; software is expected to write zero there
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= (aw_index == {1'b0, IDX_CTRL} || aw_index == {1'b0, IDX_HIGH} ||
                  aw_index == {1'b0, IDX_LOW} || aw_index == {1'b0, IDX_RSVD}) ?
                 `RESP_OKAY : `RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      test_path_control <= `RST_TEST_PATH_CONTROL;
    end else if (do_write && aw_index == {1'b0, IDX_CTRL} && w_strb[0]) begin
      test_path_control <= w_data[7:0];
    end
  end

  // ---------------- axi4-lite read side ----------------
  logic [8:0] ar_index;

  assign ar_index = word_index(i_araddr);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `RESP_OKAY;
    end else begin
      o_arready <= !o_arready && !o_rvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp <= `RESP_OKAY;
        case (ar_index)
          {1'b0, IDX_CTRL}: o_rdata <= {24'h000000, test_path_control};
          {1'b0, IDX_HIGH}: o_rdata <= {24'h000000, code_word[15:8]};
          {1'b0, IDX_LOW}: o_rdata <= {24'h000000, code_word[7:0]};
          {1'b0, IDX_RSVD}: o_rdata <= 32'h0000_0000;
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- converter path controls ----------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_analog_input_stage_bypass <= 1'b0;
      o_correction_bypass <= 1'b0;
      o_raw_low_select <= 1'b0;
    end else begin
      o_analog_input_stage_bypass <= (test_mode != pixel_test_pkg::MODE_NORMAL);
      o_correction_bypass <= test_mode[1];
      o_raw_low_select <= (test_mode == pixel_test_pkg::MODE_RAW_LOW);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_sample_falling_edge <= 1'b0;
      o_second_lamp_output <= 1'b0;
    end else begin
      o_sample_falling_edge <= test_path_control[`FLD_FALLING_EDGE];
      o_second_lamp_output <= test_path_control[`FLD_STROBE_TO_LAMP] ?
                              i_correlated_sampling_strobe : i_lamp_normal;
    end
  end

  // code registers freeze while they are the divider source, giving a known value
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      code_word <= 16'h0000;
    end else if (i_conv_valid && input_sel != pixel_test_pkg::SRC_CODE_REGS) begin
      code_word <= {i_conv_code, {`CONV_PAD_BITS{1'b0}}};
    end
  end

  // ---------------- test counter and divider source ----------------
  logic count_clear;

  assign count_clear = (input_sel == pixel_test_pkg::SRC_SCAN_COUNTER && i_scan_start) ||
                       (input_sel == pixel_test_pkg::SRC_LINE_COUNTER && i_line_start);

  pixel_test_counter #(
    .WIDTH(16)
  ) i_pixel_test_counter (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(count_clear),
    .i_pixel(i_conv_valid && !count_clear),
    .i_step_sel(step_sel),
    .o_count(count)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_valid <= 1'b0;
      div_data <= 16'h0000;
    end else begin
      div_valid <= i_conv_valid;
      case (input_sel)
        pixel_test_pkg::SRC_CONVERTER: div_data <= {i_conv_code, {`CONV_PAD_BITS{1'b0}}};
        pixel_test_pkg::SRC_CODE_REGS: div_data <= code_word;
        default: div_data <= count;
      endcase
    end
  end

  resolution_averager #(
    .DATA_W(16),
    .MAX_DIV(MAX_DIV)
  ) i_resolution_averager (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_line_start(i_line_start),
    .i_divide_by(i_divide_by),
    .i_valid(div_valid),
    .i_data(div_data),
    .o_valid(o_pix_valid),
    .o_data(o_pix_data)
  );

  // ---------------- checks ----------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_code_format;
    (i_conv_valid && input_sel != pixel_test_pkg::SRC_CODE_REGS) |=>
      code_word == {$past(i_conv_code), 2'b00};
  endproperty
  a_code_format: assert property (p_code_format) else $error("code word misformatted");

  property p_read_high;
    (o_arready && i_arvalid && ar_index == {1'b0, IDX_HIGH}) |=>
      o_rvalid && o_rdata == {24'h000000, $past(code_word[15:8])};
  endproperty
  a_read_high: assert property (p_read_high) else $error("high code byte read wrong");

  property p_bypass_analog;
    $changed(test_mode) |=> o_analog_input_stage_bypass == ($past(test_mode) != 2'b00);
  endproperty
  a_bypass_analog: assert property (p_bypass_analog) else $error("analog bypass wrong");

  property p_raw_half;
    (test_mode == pixel_test_pkg::MODE_RAW_LOW) [*2] |-> o_correction_bypass && o_raw_low_select;
  endproperty
  a_raw_half: assert property (p_raw_half) else $error("raw low mode not applied");

  property p_scan_clear;
    (input_sel == pixel_test_pkg::SRC_SCAN_COUNTER && i_scan_start) |=> count == 16'h0000;
  endproperty
  a_scan_clear: assert property (p_scan_clear) else $error("counter not cleared at scan");

  property p_line_clear;
    (input_sel == pixel_test_pkg::SRC_LINE_COUNTER && i_line_start) |=> count == 16'h0000;
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("counter not cleared at line");

  property p_step_four;
    (i_conv_valid && !count_clear && step_sel == pixel_test_pkg::STEP_FOUR) |=>
      count == 16'($past(count) + 16'h0004);
  endproperty
  a_step_four: assert property (p_step_four) else $error("counter step of four wrong");

  property p_counter_source;
    (input_sel == pixel_test_pkg::SRC_LINE_COUNTER && !$changed(input_sel)) |=>
      div_data == $past(count) && div_valid == $past(i_conv_valid);
  endproperty
  a_counter_source: assert property (p_counter_source) else $error("divider source wrong");

  property p_edge_select;
    !test_path_control[`FLD_FALLING_EDGE] [*2] |-> !o_sample_falling_edge;
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("edge select wrong");

  property p_lamp_route;
    test_path_control[`FLD_STROBE_TO_LAMP] |=>
      o_second_lamp_output == $past(i_correlated_sampling_strobe);
  endproperty
  a_lamp_route: assert property (p_lamp_route) else $error("lamp pin not routed");

endmodule : pixel_path_test_mode_control

`default_nettype wire

// ===== common/pixel_test_defs.svh
// register offsets, field positions, reset values and bus codes of the pixel test control
`ifndef PIXEL_TEST_DEFS_SVH
`define PIXEL_TEST_DEFS_SVH

// register indices as printed; byte address is four times the index
`define IDX_TEST_PATH_CONTROL 8'h5b
`define IDX_CONVERTER_CODE_HIGH 8'h5c
`define IDX_CONVERTER_CODE_LOW 8'h5d
`define IDX_RESERVED_FIRST 8'h5e

// test_path_control fields
`define FLD_TEST_MODE_LSB 0
`define FLD_TEST_MODE_MSB 1
`define FLD_INPUT_SEL_LSB 2
`define FLD_INPUT_SEL_MSB 3
`define FLD_STEP_SEL_LSB 4
`define FLD_STEP_SEL_MSB 5
`define FLD_FALLING_EDGE 6
`define FLD_STROBE_TO_LAMP 7
`define RST_TEST_PATH_CONTROL 8'h00

// converter word format
`define CONV_CODE_W 14
`define CONV_PAD_BITS 2

// counter steps
`define STEP_BY_1 16'h0001
`define STEP_BY_4 16'h0004
`define STEP_BY_16 16'h0010

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== common/pixel_test_pkg.sv
// types shared by the pixel test control blocks
`default_nettype none
package pixel_test_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_BYPASS_ANALOG,
    MODE_RAW_HIGH,
    MODE_RAW_LOW
  } test_mode_t;

  typedef enum logic [1:0] {
    SRC_CONVERTER,
    SRC_CODE_REGS,
    SRC_SCAN_COUNTER,
    SRC_LINE_COUNTER
  } input_sel_t;

  typedef enum logic [1:0] {
    STEP_ONE,
    STEP_FOUR,
    STEP_SIXTEEN,
    STEP_UNUSED
  } step_sel_t;

endpackage : pixel_test_pkg

`default_nettype wire

// ===== design/pixel_test_counter.sv
// 16-bit test counter stepping per data pixel, cleared per scan or per line
`timescale 1ns/10ps
`default_nettype none
`include "pixel_test_defs.svh"

module pixel_test_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic i_clear,
  input wire logic i_pixel,
  input wire pixel_test_pkg::step_sel_t i_step_sel,
  // count
  output logic [WIDTH-1:0] o_count
);

  generate
    if (WIDTH != 16) begin : g_bad_width
      $error("pixel_test_counter supports only a 16-bit count");
    end
  endgenerate

  logic [WIDTH-1:0] step;

  always_comb begin
    case (i_step_sel)
      pixel_test_pkg::STEP_ONE: step = `STEP_BY_1;
      pixel_test_pkg::STEP_FOUR: step = `STEP_BY_4;
      pixel_test_pkg::STEP_SIXTEEN: step = `STEP_BY_16;
      // undefined code: the count holds rather than guessing a step
      default: step = '0;
    endcase
  end

  // the sum wraps naturally past full scale
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_clear) begin
      o_count <= '0;
    end else if (i_pixel) begin
      o_count <= o_count + step;
    end
  end

endmodule : pixel_test_counter

`default_nettype wire

// ===== design/resolution_averager.sv
// horizontal resolution divider: averages groups of adjacent pixels
`timescale 1ns/10ps
`default_nettype none

module resolution_averager #(
  parameter int DATA_W = 16,
  parameter int MAX_DIV = 12
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // line framing and group size
  input wire logic i_line_start,
  input wire logic [3:0] i_divide_by,
  // incoming pixels
  input wire logic i_valid,
  input wire logic [DATA_W-1:0] i_data,
  // averaged pixels
  output logic o_valid,
  output logic [DATA_W-1:0] o_data
);

  localparam int SUM_W = DATA_W + 4;

  generate
    if (MAX_DIV > 15 || MAX_DIV < 1) begin : g_bad_div
      $error("resolution_averager group size must fit four bits");
    end
  endgenerate

  logic [SUM_W-1:0] sum;
  logic [3:0] taken;
  logic [3:0] group;
  logic [SUM_W-1:0] total;

  // zero or oversized settings fall back to pass-through
  assign group = (i_divide_by == 4'h0 || i_divide_by > 4'(MAX_DIV)) ? 4'h1 : i_divide_by;
  assign total = sum + {4'h0, i_data};

  // a partial group at the end of a line is dropped by the restart
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_line_start) begin
      sum <= '0;
      taken <= 4'h0;
    end else if (i_valid) begin
      if (taken + 4'h1 == group) begin
        sum <= '0;
        taken <= 4'h0;
      end else begin
        sum <= total;
        taken <= taken + 4'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      o_valid <= i_valid && !i_line_start && (taken + 4'h1 == group);
      if (i_valid && (taken + 4'h1 == group)) begin
        o_data <= DATA_W'(total / {{(SUM_W-4){1'b0}}, group});
      end
    end
  end

endmodule : resolution_averager

`default_nettype wire

// ===== dv/pixel_path_test_mode_control_test.sv
// self-checking testbench for the pixel path test mode control
`timescale 1ns/10ps
`default_nettype none
`include "pixel_test_defs.svh"

`define EXPECT_EQ(act, exp) begin \
  checks_done++; \
  if ((act) !== (exp)) begin \
    err_total++; \
    $display("[ERR] %0t got %h want %h", $time, act, exp); \
  end \
end

module pixel_path_test_mode_control_test;
  localparam logic [11:0] A_CTRL = {2'b00, `IDX_TEST_PATH_CONTROL, 2'b00};
  localparam logic [11:0] A_HIGH = {2'b00, `IDX_CONVERTER_CODE_HIGH, 2'b00};
  localparam logic [11:0] A_LOW = {2'b00, `IDX_CONVERTER_CODE_LOW, 2'b00};
  localparam logic [11:0] A_RSV = {2'b00, `IDX_RESERVED_FIRST, 2'b00};
  logic i_core_clk, i_rst;
  logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic i_arvalid, o_arready, o_rvalid, i_rready;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb, i_divide_by;
  logic [1:0] o_bresp, o_rresp;
  logic i_conv_valid, i_scan_start, i_line_start, i_correlated_sampling_strobe, i_lamp_normal;
  logic [13:0] i_conv_code;
  logic o_analog_input_stage_bypass, o_correction_bypass, o_raw_low_select;
  logic o_sample_falling_edge, o_second_lamp_output, o_pix_valid;
  logic [15:0] o_pix_data;
  int err_total = 0;
  int checks_done = 0;
  logic [15:0] pq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] ctrl = 8'h00;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] cap = 16'h0000;
  logic [15:0] stepv[4] = '{16'h0001, 16'h0004, 16'h0010, 16'h0000};
  int dv = 1;
  // each note is taken off its queue once, before the compare macro reads it twice
  logic [15:0] p_exp;
  logic [33:0] r_exp;
  logic [1:0] b_exp;

  pixel_path_test_mode_control i_pixel_path_test_mode_control (.*);

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  task end_of_test;
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // results are judged where they appear, against notes left by the drivers
  always @(posedge i_core_clk) begin
    if (o_pix_valid === 1'b1) begin
      if (pq.size() == 0) begin
        err_total++;
        $display("[ERR] %0t unexpected pixel", $time);
      end else begin
        p_exp = pq.pop_front();
        `EXPECT_EQ(o_pix_data, p_exp)
      end
    end
    if (o_rvalid === 1'b1 && i_rready && rq.size() > 0) begin
      r_exp = rq.pop_front();
      `EXPECT_EQ({o_rresp, o_rdata}, r_exp)
    end
    if (o_bvalid === 1'b1 && i_bready && bq.size() > 0) begin
      b_exp = bq.pop_front();
      `EXPECT_EQ(o_bresp, b_exp)
    end
  end

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    bq.push_back(r);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready === 1'b1) begin
        aw = 1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready === 1'b1) begin
        w = 1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_core_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    // a following call must not raise bready in the time step that lowered it
    @(posedge i_core_clk);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do @(posedge i_core_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    @(posedge i_core_clk);
  endtask : rd

  task set_ctrl(input logic [7:0] c);
    ctrl = c;
    wr(A_CTRL, {24'h0, c}, `RESP_OKAY);
    repeat (2) @(posedge i_core_clk);
  endtask : set_ctrl

  // one-cycle scan or line start; the model clears only when the source matches
  task frame(input bit scan, input int div);
    dv = div;
    i_divide_by <= 4'(div);
    if (scan) i_scan_start <= 1'b1;
    else i_line_start <= 1'b1;
    @(posedge i_core_clk);
    i_scan_start <= 1'b0;
    i_line_start <= 1'b0;
    if (ctrl[3:2] == (scan ? 2'd2 : 2'd3)) cnt = 16'h0000;
  endtask : frame

  task run_pix(input int n);
    int sum;
    logic [13:0] c;
    logic [15:0] w;
    sum = 0;
    for (int i = 0; i < n; i++) begin
      c = 14'($urandom);
      i_conv_valid <= 1'b1;
      i_conv_code <= c;
      case (ctrl[3:2])
        2'd0: w = {c, 2'b00};
        2'd1: w = cap;
        default: w = cnt;
      endcase
      if (ctrl[3:2] != 2'd1) cap = {c, 2'b00};
      cnt = cnt + stepv[ctrl[5:4]];
      sum += w;
      if ((i + 1) % dv == 0) begin
        pq.push_back(16'(sum / dv));
        sum = 0;
      end
      @(posedge i_core_clk);
    end
    i_conv_valid <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask : run_pix

  initial begin
    repeat (30000) @(posedge i_core_clk);
    err_total++;
    end_of_test();
  end

  initial begin
    logic s;
    logic l;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hf;
    i_divide_by = 4'h1;
    {i_conv_valid, i_scan_start, i_line_start} = '0;
    i_conv_code = 14'h0000;
    {i_correlated_sampling_strobe, i_lamp_normal} = '0;
    i_rst = 1'b1;
    void'($urandom(14006));
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    `EXPECT_EQ(o_sample_falling_edge, 1'b0)
    rd(A_CTRL, 32'h0, `RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      set_ctrl(8'(m));
      `EXPECT_EQ(o_analog_input_stage_bypass, 1'(m != 0))
      `EXPECT_EQ(o_correction_bypass, 1'(m >= 2))
      `EXPECT_EQ(o_raw_low_select, 1'(m == 3))
      rd(A_CTRL, 32'(m), `RESP_OKAY);
    end
    set_ctrl(8'h40);
    `EXPECT_EQ(o_sample_falling_edge, 1'b1)
    for (int k = 0; k < 8; k++) begin
      set_ctrl({k[0], 7'h0});
      s = 1'($urandom);
      l = 1'($urandom);
      i_correlated_sampling_strobe <= s;
      i_lamp_normal <= l;
      repeat (3) @(posedge i_core_clk);
      `EXPECT_EQ(o_second_lamp_output, k[0] ? s : l)
    end
    // converter source, then the frozen code registers as source
    set_ctrl(8'h00);
    frame(0, 1);
    run_pix(5);
    rd(A_HIGH, {24'h0, cap[15:8]}, `RESP_OKAY);
    rd(A_LOW, {24'h0, cap[7:0]}, `RESP_OKAY);
    set_ctrl(8'h04);
    frame(0, 1);
    run_pix(4);
    rd(A_HIGH, {24'h0, cap[15:8]}, `RESP_OKAY);
    // per-line counter with every step code
    for (int st = 0; st < 4; st++) begin
      set_ctrl({2'b00, 2'(st), 4'b1100});
      frame(0, 1);
      run_pix(6);
    end
    // per-scan counter survives a line start
    set_ctrl(8'h18);
    frame(1, 1);
    run_pix(3);
    frame(0, 1);
    run_pix(3);
    set_ctrl(8'h2c);
    frame(0, 1);
    run_pix(4100);
    set_ctrl(8'h00);
    foreach (stepv[j]) begin
      frame(0, j == 3 ? 12 : j + 2);
      run_pix(3 * dv + 1);
    end
    // bus refusals and the reserved word
    rd(12'h200, 32'h0, `RESP_SLVERR);
    rd(A_CTRL + 12'h1, 32'h0, `RESP_SLVERR);
    wr(A_CTRL + 12'h2, 32'hff, `RESP_SLVERR);
    wr(A_RSV, 32'h0, `RESP_OKAY);
    rd(A_RSV, 32'h0, `RESP_OKAY);
    rd(A_CTRL, {24'h0, ctrl}, `RESP_OKAY);
    repeat (5) @(posedge i_core_clk);
    `EXPECT_EQ(pq.size() + rq.size() + bq.size(), 0)
    end_of_test();
  end
endmodule : pixel_path_test_mode_control_test

`default_nettype wire
